// ===== core/sepp_device.sv
module sepp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Filling side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Draining side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW:0]      wr_ptr;
    logic [PW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign in_ready_out  = (wr_ptr - rd_ptr) != (PW + 1)'(DEPTH);
    assign out_valid_out = wr_ptr != rd_ptr;
    assign out_data_out  = store[rd_ptr[PW-1:0]];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            store[wr_ptr[PW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

module sepp_device #(
    parameter int PROG_CYCLES = sepp_pkg::PROG_CYCLES,
    parameter int ERASE_ALL_CYCLES = sepp_pkg::ERASE_ALL_CYCLES,
    parameter int WRITE_ALL_CYCLES = sepp_pkg::WRITE_ALL_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Pins from the master
    input  wire logic select_in,
    input  wire logic sclk_in,
    input  wire logic serial_in,
    input  wire logic word_width_select_in,
    // Serial output pin
    output logic      serial_out,
    output logic      serial_oe_n_out,
    // Power state
    output logic      standby_out
);
    localparam int AW = sepp_pkg::ADDR_BITS;
    localparam int TW = sepp_pkg::TIMER_BITS;

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_READ, ST_DONE} sepp_state_type;

    logic [2:0]                 sel_q, ck_q, din_q, wid_q;
    logic                       sel_s, din_s, wid_s, clk_rise, sel_fall;
    sepp_state_type             state;
    logic [4:0]                 cnt, aw, dw;
    logic [15:0]                sh, nsh, rword, rd_word;
    logic                       wide, enabled, drive_rd, armed, status_show, busy;
    logic [1:0]                 opc_n, ext_n;
    logic [AW-1:0]              addr_n, raddr;
    logic [4:0]                 rbits;
    logic                       dout;
    sepp_pkg::sepp_cmd_type     cand, pend, eng, fifo_out;
    logic                       cand_valid, pend_valid, pend_set;
    logic                       fifo_ready, fifo_valid, eng_active, commit;
    logic [TW-1:0]              timer;
    logic                       addr_end, data_end, all_w, erase_w;
    logic [7:0]                 mem [sepp_pkg::MEM_BYTES];

    // Pin synchronisers; edges taken from stages two and three
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sel_q <= '0;
            ck_q  <= '0;
            din_q <= '0;
            wid_q <= '0;
        end else begin
            sel_q <= {sel_q[1:0], select_in};
            ck_q  <= {ck_q[1:0], sclk_in};
            din_q <= {din_q[1:0], serial_in};
            wid_q <= {wid_q[1:0], word_width_select_in};
        end
    end
    assign sel_s    = sel_q[1];
    assign din_s    = din_q[1];
    assign wid_s    = wid_q[1];
    assign clk_rise = ck_q[1] && !ck_q[2];
    assign sel_fall = sel_q[2] && !sel_q[1];

    // Instruction decode
    assign aw       = wide ? 5'(AW - 1) : 5'(AW);
    assign dw       = wide ? 5'h10 : 5'h08;
    assign nsh      = {sh[14:0], din_s};
    assign opc_n    = wide ? nsh[AW:AW-1] : nsh[AW+1:AW];
    assign addr_n   = wide ? {1'b0, nsh[AW-2:0]} : nsh[AW-1:0];
    assign ext_n    = wide ? nsh[AW-2:AW-3] : nsh[AW-1:AW-2];
    assign addr_end = sel_s && state == ST_SHIFT && clk_rise && cnt == aw + 5'h01;
    assign data_end = sel_s && state == ST_SHIFT && clk_rise && cnt == aw + dw + 5'h01;
    assign rd_word  = wide ? {mem[{raddr[AW-2:0], 1'b0}], mem[{raddr[AW-2:0], 1'b1}]}
                           : {mem[raddr], 8'h00};

    // Serial instruction sequencer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state      <= ST_IDLE;
            cnt        <= '0;
            sh         <= '0;
            wide       <= 1'b0;
            cand       <= '0;
            cand_valid <= 1'b0;
        end else if (!sel_s) begin
            state      <= ST_IDLE;
            cnt        <= '0;
            cand_valid <= 1'b0;
        end else if (clk_rise) begin
            unique case (state)
                ST_IDLE: begin
                    if (din_s && !pend_valid) begin
                        state <= ST_SHIFT;
                        cnt   <= '0;
                        wide  <= wid_s;
                    end
                end
                ST_SHIFT: begin
                    sh  <= nsh;
                    cnt <= cnt + 5'h01;
                    if (addr_end) begin
                        cand.addr <= addr_n;
                        cand.wide <= wide;
                        cand.data <= '0;
                        unique case (opc_n)
                            sepp_pkg::OPC_READ:  state <= ST_READ;
                            sepp_pkg::OPC_WRITE: cand.op <= sepp_pkg::SEPP_PROG_WRITE;
                            sepp_pkg::OPC_ERASE: begin
                                cand.op    <= sepp_pkg::SEPP_PROG_ERASE;
                                cand_valid <= 1'b1;
                                state      <= ST_DONE;
                            end
                            sepp_pkg::OPC_EXT: begin
                                cand.op <= sepp_pkg::SEPP_PROG_WRITE_ALL;
                                if (ext_n == sepp_pkg::EXT_ERASE_ALL) begin
                                    cand.op    <= sepp_pkg::SEPP_PROG_ERASE_ALL;
                                    cand_valid <= 1'b1;
                                end
                                if (ext_n != sepp_pkg::EXT_WRITE_ALL) begin
                                    state <= ST_DONE;
                                end
                            end
                        endcase
                    end else if (data_end) begin
                        cand.data  <= wide ? nsh : {8'h00, nsh[7:0]};
                        cand_valid <= 1'b1;
                        state      <= ST_DONE;
                    end
                end
                ST_READ: state <= ST_READ;
                ST_DONE: state <= ST_DONE;
            endcase
        end
    end

    // Program enable latch; power-up disabled
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            enabled <= 1'b0;
        end else if (addr_end && opc_n == sepp_pkg::OPC_EXT) begin
            if (ext_n == sepp_pkg::EXT_EN) begin
                enabled <= 1'b1;
            end else if (ext_n == sepp_pkg::EXT_DIS) begin
                enabled <= 1'b0;
            end
        end
    end

    // Read data and status onto the output pin
    assign status_show = armed && sel_s && state == ST_IDLE;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dout     <= 1'b0;
            drive_rd <= 1'b0;
            rword    <= '0;
            rbits    <= '0;
            raddr    <= '0;
        end else if (!sel_s) begin
            drive_rd <= 1'b0;
        end else if (status_show) begin
            dout <= !busy;
        end else if (addr_end && opc_n == sepp_pkg::OPC_READ) begin
            dout     <= 1'b0;
            drive_rd <= 1'b1;
            raddr    <= addr_n;
            rbits    <= '0;
        end else if (state == ST_READ && clk_rise) begin
            if (rbits == 5'h00) begin
                dout  <= rd_word[15];
                rword <= rd_word << 1;
                rbits <= dw - 5'h01;
            end else begin
                dout  <= rword[15];
                rword <= rword << 1;
                rbits <= rbits - 5'h01;
                if (rbits == 5'h01) begin
                    raddr <= wide ? {1'b0, (AW-1)'(raddr[AW-2:0] + 1'b1)}
                                  : AW'(raddr + 1'b1);
                end
            end
        end
    end
    assign serial_out      = dout;
    assign serial_oe_n_out = !(drive_rd || status_show);

    // Hand off a programming command at the select fall
    assign pend_set = sel_fall && cand_valid && enabled && !pend_valid;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend       <= '0;
            pend_valid <= 1'b0;
        end else if (pend_set) begin
            pend       <= cand;
            pend_valid <= 1'b1;
        end else if (pend_valid && fifo_ready) begin
            pend_valid <= 1'b0;
        end
    end

    // Status armed from initiation until ready seen with select low
    assign busy = eng_active || fifo_valid || pend_valid;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            armed <= 1'b0;
        end else if (pend_set) begin
            armed <= 1'b1;
        end else if (!busy && !sel_s) begin
            armed <= 1'b0;
        end
    end
    assign standby_out = !sel_s && !busy;

    sepp_fifo #(
        .WIDTH ($bits(sepp_pkg::sepp_cmd_type)),
        .DEPTH (sepp_pkg::FIFO_DEPTH)
    ) u_queue (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .in_valid_in   (pend_valid),
        .in_ready_out  (fifo_ready),
        .in_data_in    (pend),
        .out_valid_out (fifo_valid),
        .out_ready_in  (!eng_active),
        .out_data_out  (fifo_out)
    );

    // Self-timed programming engine, no serial clock used
    assign commit = eng_active && timer == TW'(1);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            eng        <= '0;
            eng_active <= 1'b0;
            timer      <= '0;
        end else if (!eng_active && fifo_valid) begin
            eng        <= fifo_out;
            eng_active <= 1'b1;
            unique case (fifo_out.op)
                sepp_pkg::SEPP_PROG_ERASE_ALL: timer <= TW'(ERASE_ALL_CYCLES);
                sepp_pkg::SEPP_PROG_WRITE_ALL: timer <= TW'(WRITE_ALL_CYCLES);
                default:                       timer <= TW'(PROG_CYCLES);
            endcase
        end else if (eng_active) begin
            timer <= timer - TW'(1);
            if (commit) begin
                eng_active <= 1'b0;
            end
        end
    end

    assign all_w   = eng.op == sepp_pkg::SEPP_PROG_ERASE_ALL
                  || eng.op == sepp_pkg::SEPP_PROG_WRITE_ALL;
    assign erase_w = eng.op == sepp_pkg::SEPP_PROG_ERASE
                  || eng.op == sepp_pkg::SEPP_PROG_ERASE_ALL;

    for (genvar i = 0; i < sepp_pkg::MEM_BYTES; i++) begin : g_byte
        localparam logic [AW-1:0] IDX = AW'(i);
        logic hit;
        assign hit = commit && (all_w || (eng.wide ? IDX[AW-1:1] == eng.addr[AW-2:0]
                                                   : IDX == eng.addr));
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                mem[i] <= sepp_pkg::ERASED_BYTE;
            end else if (hit) begin
                if (erase_w) begin
                    mem[i] <= sepp_pkg::ERASED_BYTE;
                end else if (eng.wide && !IDX[0]) begin
                    mem[i] <= eng.data[15:8];
                end else begin
                    mem[i] <= eng.data[7:0];
                end
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_start;
        state == ST_IDLE && sel_s && clk_rise && din_s && !pend_valid;
    endsequence
    sequence s_read_addr;
        addr_end && opc_n == sepp_pkg::OPC_READ;
    endsequence

    property p_desel_reset;
        !sel_s |=> state == ST_IDLE && !cand_valid;
    endproperty
    a_desel_reset: assert property (p_desel_reset) else $error("not reset while deselected");
    property p_release;
        !sel_s ##1 !sel_s |-> serial_oe_n_out;
    endproperty
    a_release: assert property (p_release) else $error("output driven while deselected");
    property p_start;
        s_start |=> state == ST_SHIFT && cnt == 5'h00;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_wait_start;
        state == ST_IDLE && sel_s && !din_s |=> state == ST_IDLE;
    endproperty
    a_wait_start: assert property (p_wait_start) else $error("left idle without start");
    property p_pause;
        state == ST_SHIFT && sel_s && !clk_rise |=> $stable(cnt) && $stable(sh);
    endproperty
    a_pause: assert property (p_pause) else $error("moved without clock edge");
    property p_dummy;
        s_read_addr ##1 sel_s |-> !serial_out && !serial_oe_n_out;
    endproperty
    a_dummy: assert property (p_dummy) else $error("no dummy zero");
    property p_status_busy;
        status_show && busy ##1 status_show |-> !serial_out;
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("busy not low");
    property p_enable_gate;
        $rose(pend_valid) |-> $past(enabled);
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("program while disabled");
    property p_runs;
        eng_active && timer > TW'(1) |=> eng_active;
    endproperty
    a_runs: assert property (p_runs) else $error("programming aborted");
endmodule

// ===== inc/sepp_pkg.sv
package sepp_pkg;
    // Clock rate of this block's own clock
    localparam int CLK_MHZ         = 250;
    // Self-timed programming durations, microseconds
    localparam int PROG_TIME_US    = 4000;
    localparam int ERASE_ALL_TIME_US = 8000;
    localparam int WRITE_ALL_TIME_US = 16000;
    localparam int PROG_CYCLES       = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_ALL_CYCLES  = ERASE_ALL_TIME_US * CLK_MHZ;
    localparam int WRITE_ALL_CYCLES  = WRITE_ALL_TIME_US * CLK_MHZ;
    localparam int TIMER_BITS      = 24;
    // Array geometry: x16 word address width, byte address one wider
    localparam int ADDR16_BITS     = 8;
    localparam int ADDR_BITS       = ADDR16_BITS + 1;
    localparam int MEM_BYTES       = 2 ** ADDR_BITS;
    localparam int DATA_BITS       = 16;
    localparam int FIFO_DEPTH      = 32;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Opcodes following the start bit
    localparam logic [1:0] OPC_EXT   = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ  = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    // Extended codes in the top two address bits
    localparam logic [1:0] EXT_DIS   = 2'h0;
    localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
    localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [1:0] EXT_EN    = 2'h3;

    typedef enum logic [1:0] {
        SEPP_PROG_WRITE,
        SEPP_PROG_ERASE,
        SEPP_PROG_ERASE_ALL,
        SEPP_PROG_WRITE_ALL
    } sepp_prog_type;

    typedef struct packed {
        sepp_prog_type          op;
        logic                   wide;
        logic [ADDR_BITS-1:0]   addr;
        logic [DATA_BITS-1:0]   data;
    } sepp_cmd_type;
endpackage

// ===== bench/sepp_master.sv
module sepp_master (
    // Line back from the device
    input  wire logic sdo_in,
    input  wire logic sdo_oe_n_in,
    // Pins toward the device
    output logic      sel_out,
    output logic      sclk_out,
    output logic      sdi_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic    line;
    realtime fall_time;

    // Pull-up holds a released output high
    assign line = sdo_oe_n_in ? 1'b1 : sdo_in;

    initial begin
        sel_out   = 1'b0;
        sclk_out  = 1'b0;
        sdi_out   = 1'b0;
        fall_time = 0.0;
    end

    // One rising edge, with random pauses at either level
    task automatic pulse(input logic b, output logic r);
        sdi_out = b;
        #(24 + 40 * $urandom_range(0, 1));
        sclk_out = 1'b1;
        #22 r = line;
        #(2 + 40 * $urandom_range(0, 1));
        sclk_out = 1'b0;
    endtask

    task automatic open_sel(input int idle);
        logic r;
        sel_out = 1'b1;
        #40;
        repeat (idle) pulse(1'b0, r);
    endtask

    task automatic close_sel();
        sel_out   = 1'b0;
        fall_time = $realtime;
        #300;
    endtask

    task automatic send(input int n, input logic [15:0] v, output logic r);
        for (int i = n - 1; i >= 0; i--) pulse(v[i], r);
    endtask

    task automatic recv(input int n, output logic [15:0] v);
        logic r;
        v = '0;
        for (int i = n - 1; i >= 0; i--) begin
            pulse(1'b0, r);
            v[i] = r;
        end
    endtask

    // Reselect without clocks; time from select fall until ready, or -1
    task automatic poll(input int limit_ns, output logic first, output int ready_ns);
        sel_out = 1'b1;
        #40 first = line;
        ready_ns = -1;
        for (int t = 0; t < limit_ns / 4 && ready_ns < 0; t++) begin
            #4;
            if (line === 1'b1) ready_ns = int'($realtime - fall_time);
        end
    endtask
endmodule

// ===== bench/sepp_device_tb.sv
module sepp_device_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PROG = 400;
    localparam int ERASE_ALL = 800;
    localparam int WRITE_ALL = 1600;

    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       wide   = 1'b1;
    logic       sel, sclk, sdi, sdo, sdo_oe_n, standby;
    logic [7:0] mem [512];
    logic       enabled = 1'b0;
    int         errors = 0;
    int         total_checks = 0;

    always #2 clk_in = ~clk_in;

    sepp_device #(.PROG_CYCLES(PROG), .ERASE_ALL_CYCLES(ERASE_ALL),
                  .WRITE_ALL_CYCLES(WRITE_ALL)) DUT (
        .clk_in(clk_in), .rst_in(rst_in), .select_in(sel), .sclk_in(sclk),
        .serial_in(sdi), .word_width_select_in(wide), .serial_out(sdo),
        .serial_oe_n_out(sdo_oe_n), .standby_out(standby));
    sepp_master master (.sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n), .sel_out(sel),
        .sclk_out(sclk), .sdi_out(sdi));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [8:0] ext_addr(logic [1:0] code);
        return wide ? {1'b0, code, 6'h00} : {code, 7'h00};
    endfunction

    function automatic logic [15:0] expect_word(logic [8:0] a);
        return wide ? {mem[{a[7:0], 1'b0}], mem[{a[7:0], 1'b1}]} : {8'h00, mem[a]};
    endfunction

    task automatic set_wide(input logic w);
        @(posedge clk_in);
        #1 wide = w;
    endtask

    task automatic op(input logic [1:0] opc, input logic [8:0] addr, input logic [15:0] data,
                      input int extra, output logic [15:0] rd, output logic dummy);
        logic       r;
        logic [1:0] ext;
        logic [15:0] v;
        int         aa;
        ext = wide ? addr[7:6] : addr[8:7];
        rd  = '0;
        master.open_sel($urandom_range(0, 3));
        master.send(3, {13'h0000, 1'b1, opc}, r);
        master.send(wide ? 8 : 9, {7'h00, addr}, dummy);
        if (opc == sepp_pkg::OPC_READ) master.recv(wide ? 16 : 8, rd);
        else if (opc == sepp_pkg::OPC_WRITE || (opc == sepp_pkg::OPC_EXT
                 && ext == sepp_pkg::EXT_WRITE_ALL)) master.send(wide ? 16 : 8, data, r);
        repeat (extra) master.pulse(1'b1, r);
        master.close_sel();
        if (opc == sepp_pkg::OPC_EXT && ext == sepp_pkg::EXT_EN) enabled = 1'b1;
        if (opc == sepp_pkg::OPC_EXT && ext == sepp_pkg::EXT_DIS) enabled = 1'b0;
        if (enabled && opc == sepp_pkg::OPC_EXT) begin
            for (int b = 0; b < 512; b++) begin
                if (ext == sepp_pkg::EXT_ERASE_ALL) mem[b] = 8'hFF;
                if (ext == sepp_pkg::EXT_WRITE_ALL) mem[b] = (wide && !b[0]) ? data[15:8]
                                                                           : data[7:0];
            end
        end
        if (enabled && (opc == sepp_pkg::OPC_WRITE || opc == sepp_pkg::OPC_ERASE)) begin
            v  = (opc == sepp_pkg::OPC_ERASE) ? 16'hFFFF : data;
            aa = wide ? 2 * int'(addr[7:0]) : int'(addr);
            if (wide) mem[aa] = v[15:8];
            mem[aa + (wide ? 1 : 0)] = v[7:0];
        end
    endtask

    task automatic rd_check(input logic [8:0] a);
        logic [15:0] rd;
        logic        dm;
        op(sepp_pkg::OPC_READ, a, 16'h0000, 0, rd, dm);
        check("read data", expect_word(a), rd);
        check("dummy bit", 16'h0000, dm);
    endtask

    task automatic prog_wait(input int cycles);
        logic first;
        int   t;
        check("standby while busy", 16'h0000, standby);
        master.poll(cycles * 4 + 400, first, t);
        check("status busy", 16'h0000, first);
        check("ready time", 16'h0001, t >= cycles * 4 && t <= cycles * 4 + 80);
        master.close_sel();
        check("released after status", 16'h0001, sdo_oe_n);
        check("standby after cycle", 16'h0001, standby);
    endtask

    initial begin
        #300000;
        errors++;
        $display("CHECK FAILED watchdog expected done seen hang");
        final_report();
    end

    initial begin
        logic [15:0] rd, d;
        logic [8:0]  a;
        logic        dm, r;
        int          t;
        void'($urandom(2));
        for (int b = 0; b < 512; b++) mem[b] = 8'hFF;
        repeat (20) @(posedge clk_in);
        #1 rst_in = 1'b0;
        @(posedge clk_in);
        #1 check("standby after reset", 16'h0001, standby);
        check("released after reset", 16'h0001, sdo_oe_n);
        a = 9'($urandom_range(0, 255));
        op(sepp_pkg::OPC_WRITE, a, 16'($urandom), 0, rd, dm);
        check("refused write launches nothing", 16'h0001, standby);
        rd_check(a);
        op(sepp_pkg::OPC_EXT, ext_addr(sepp_pkg::EXT_EN), 16'h0000, 0, rd, dm);
        check("released after enable", 16'h0001, dm);
        $display("test protection done");
        // Erase then write each of two adjacent words, queued behind each other
        a = 9'($urandom_range(0, 254));
        for (int k = 0; k < 4; k++) begin
            op(k[0] ? sepp_pkg::OPC_WRITE : sepp_pkg::OPC_ERASE, a + 9'(k / 2),
               16'($urandom), 0, rd, dm);
        end
        check("standby while queued", 16'h0000, standby);
        master.poll(8 * PROG * 4, r, t);
        check("status busy while queued", 16'h0000, r);
        check("queue drained", 16'h0001, t > 0);
        master.close_sel();
        rd_check(a);
        rd_check(a + 9'h001);
        $display("test queue done");
        for (int i = 0; i < 4; i++) begin
            set_wide(i[0]);
            a = 9'($urandom_range(0, i[0] ? 255 : 511));
            op(sepp_pkg::OPC_WRITE, a, 16'($urandom), $urandom_range(0, 3), rd, dm);
            prog_wait(PROG);
            set_wide(~i[0]);
            rd_check(i[0] ? {a[7:0], 1'($urandom)} : {1'b0, a[8:1]});
        end
        $display("test writes done");
        master.open_sel(0);
        master.send(7, 16'h0050, r);
        master.close_sel();
        repeat (5) master.pulse(1'b1, r);
        check("aborted instruction", 16'h0001, standby);
        rd_check(a);
        op(sepp_pkg::OPC_ERASE, a, 16'h0000, 0, rd, dm);
        #(PROG * 4 + 200);
        master.open_sel(0);
        check("no status when held low", 16'h0001, sdo_oe_n);
        master.close_sel();
        rd_check(a);
        $display("test select held low done");
        op(sepp_pkg::OPC_EXT, ext_addr(sepp_pkg::EXT_ERASE_ALL), 16'h0000, 0, rd, dm);
        prog_wait(ERASE_ALL);
        rd_check(9'($urandom_range(0, 511)));
        d = 16'($urandom);
        op(sepp_pkg::OPC_EXT, ext_addr(sepp_pkg::EXT_WRITE_ALL), d, 0, rd, dm);
        prog_wait(WRITE_ALL);
        rd_check(9'($urandom_range(0, 511)));
        op(sepp_pkg::OPC_EXT, ext_addr(sepp_pkg::EXT_DIS), 16'h0000, 0, rd, dm);
        op(sepp_pkg::OPC_ERASE, a, 16'h0000, 0, rd, dm);
        check("erase after disable", 16'h0001, standby);
        rd_check(a);
        $display("test array commands done");
        final_report();
    end
endmodule
